// file: rtl/pmcs_switcher.sv
// Function
// - Select field picks source: 00 primary, 01 auxiliary, 1x internal block.
// - Changing the select starts an immediate switch if the new source is ready.
// - Halt enters Sleep when idle bit clear, else the matching Idle mode unless selected auxiliary is disabled.
// - Sleep stops CPU and peripheral clocks and disables the primary oscillator only.
// - Run modes clock core and peripherals from the current source only.
// - Idle bit is sampled at the halt to choose Sleep or Idle.
// - Each later halt uses the idle bit value current at that halt.
// - Handover takes two old-source cycles plus three new-source cycles.
// - Primary-active status reads one while primary clocks the device.
// - Fast-RC-stable reads one while stable fast internal clock drives device.
// - Aux-active status reads one while auxiliary oscillator clocks the device.
// - Normally one status bit set; none set means slow or unstable internal.
// - Internal primary config lets primary-active and fast-stable both read one.
// - Then moving to internal mode at same rate clears primary-active.
// - Reset starts primary run with primary-active set unless two-speed start.
// - Selecting auxiliary switches to it, stops primary, updates both status bits.
// - Auxiliary run is not entered while the auxiliary enable is clear.
// - Enabled but silent auxiliary oscillator withholds device clocks until running.
// - Returning to primary keeps auxiliary clock until primary ready, then swaps.
// - Return switch leaves select and idle bits alone; auxiliary keeps running.
// - Crystal primary counts ready at reset, otherwise only after 1024 oscillator cycles.
// - Selecting internal block stops primary oscillator and clears primary-active.
// - Sleep stops the primary oscillator and clears all clock status bits.
module pmcs_switcher #(
	parameter int WARM_CNT = pmcs_pkg::WARMUP_CYCLES
) (
	input  wire logic        clk,               // 200 MHz system clock
	input  wire logic        sys_rst,           // Synchronous reset, high
	input  wire logic [1:0]  clkSourceSelect,   // Source select field
	input  wire logic        idleOnHalt,        // Idle instead of Sleep
	input  wire logic        auxOscEnable,      // Auxiliary oscillator enable
	input  wire logic        haltExec,          // Halt instruction pulse
	input  wire logic        wakeEvent,         // Wake pulse
	input  wire logic        primaryIsInternal, // Config: primary is internal
	input  wire logic        twoSpeedStartup,   // Config: two-speed start
	input  wire logic        priOscPin,         // Primary oscillator level
	input  wire logic        auxOscPin,         // Auxiliary oscillator level
	input  wire logic        intOscPin,         // Internal block level
	input  wire logic        fastRcReadyPin,    // Fast internal stable level
	output logic             cpuTick,           // CPU clock enable pulse
	output logic             periphTick,        // Peripheral clock enable pulse
	output logic             primaryOscEn,      // Primary oscillator enable
	output logic             primaryClkActive,  // Status, control reg bit 3
	output logic             fastRcStable,      // Status, control reg bit 2
	output logic             auxOscActive,      // Status, timer reg bit 6
	output logic [1:0]       powerMode,         // Current mode code
	output logic             switchBusy         // Handover in progress
);

	localparam int WARM_W = $clog2(WARM_CNT);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detect per oscillator
	wire logic [2:0] oscPin = {intOscPin, auxOscPin, priOscPin};
	logic [2:0] oscMeta_r, oscSync_r, oscPrev_r;
	logic [2:0] srcTick;

	genvar gi;
	generate
		for (gi = 0; gi < pmcs_pkg::NUM_SRC; gi++) begin : g_osc
			// Meta stage is read only by the sync stage
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					oscMeta_r[gi] <= 1'b0;
					oscSync_r[gi] <= 1'b0;
					oscPrev_r[gi] <= 1'b0;
				end else begin
					oscMeta_r[gi] <= oscPin[gi];
					oscSync_r[gi] <= oscMeta_r[gi];
					oscPrev_r[gi] <= oscSync_r[gi];
				end
			end
			assign srcTick[gi] = oscSync_r[gi] & ~oscPrev_r[gi];
		end
	endgenerate

	// Fast internal stable flag, two stages
	logic rcMeta_r, rcSync_r;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rcMeta_r <= 1'b0;
			rcSync_r <= 1'b0;
		end else begin
			rcMeta_r <= fastRcReadyPin;
			rcSync_r <= rcMeta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source decode and readiness
	pmcs_pkg::pmcs_mode_t mode_r, mode_nxt;
	logic              warmDone_r, warmDone_nxt;
	logic [WARM_W-1:0] warmCnt_r, warmCnt_nxt;
	logic              priEn_r;
	logic [1:0]        curSrc;
	logic              busy;
	logic              devTick;

	wire logic [1:0] wantSrc = clkSourceSelect[pmcs_pkg::SEL_INT_BIT] ? pmcs_pkg::SRC_INT :
		(clkSourceSelect == pmcs_pkg::SEL_AUX) ? pmcs_pkg::SRC_AUX : pmcs_pkg::SRC_PRI;
	wire logic auxBlocked = (wantSrc == pmcs_pkg::SRC_AUX) & ~auxOscEnable;
	// Internal primary needs no start-up timer
	wire logic priReady   = primaryIsInternal | warmDone_r;
	wire logic wantReady  = (wantSrc == pmcs_pkg::SRC_PRI) ? priReady :
		(wantSrc == pmcs_pkg::SRC_AUX) ? auxOscEnable : 1'b1;
	wire logic curReady   = (curSrc == pmcs_pkg::SRC_PRI) ? priReady :
		(curSrc == pmcs_pkg::SRC_AUX) ? auxOscEnable : 1'b1;
	wire logic asleep     = (mode_r == pmcs_pkg::MD_SLEEP) | (mode_r == pmcs_pkg::MD_WAKE);
	wire logic awake      = ~asleep;

	// Handover only once the new source is ready; old one clocks meanwhile
	wire logic goReq = awake & ~busy & (wantSrc != curSrc) & ~auxBlocked & wantReady;
	// Primary runs while in use, starting for a return, or warming up after wake
	wire logic sleepNxt = (mode_nxt == pmcs_pkg::MD_SLEEP);
	wire logic priEnNxt = ~sleepNxt & ((curSrc == pmcs_pkg::SRC_PRI) | (wantSrc == pmcs_pkg::SRC_PRI));
	wire logic [1:0] resetSrc = twoSpeedStartup ? pmcs_pkg::SRC_INT : pmcs_pkg::RST_SRC;

	////////////////////////////////////////////////////////////////////////
	// Handover sequencer
	pmcs_clk_mux #(
		.OLD_CYC (pmcs_pkg::TRANS_OLD_CYC),
		.NEW_CYC (pmcs_pkg::TRANS_NEW_CYC)
	) u_mux (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.resetSrc (resetSrc),
		.srcTick  (srcTick),
		.goReq    (goReq),
		.goSrc    (wantSrc),
		.hold     (asleep),
		.curSrc   (curSrc),
		.busy     (busy),
		.devTick  (devTick)
	);

	////////////////////////////////////////////////////////////////////////
	// Start-up timer: counts primary cycles after enable
	always_comb begin
		warmCnt_nxt  = warmCnt_r;
		warmDone_nxt = warmDone_r;
		if (!priEn_r) begin
			// Oscillator stopped, so it must warm up again
			warmCnt_nxt  = '0;
			warmDone_nxt = 1'b0;
		end else if (!warmDone_r && srcTick[pmcs_pkg::SRC_PRI]) begin
			warmCnt_nxt = warmCnt_r + WARM_W'(1);
			if (warmCnt_r == WARM_W'(WARM_CNT - 1))
				warmDone_nxt = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode sequencing on halt and wake
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			pmcs_pkg::MD_RUN: begin
				if (haltExec) begin
					// Idle bit taken as it stands at this halt
					if (!idleOnHalt)
						mode_nxt = pmcs_pkg::MD_SLEEP;
					else if (!auxBlocked)
						mode_nxt = pmcs_pkg::MD_IDLE;
				end
			end
			pmcs_pkg::MD_IDLE: begin
				if (wakeEvent)
					mode_nxt = pmcs_pkg::MD_RUN;
			end
			pmcs_pkg::MD_SLEEP: begin
				if (wakeEvent)
					mode_nxt = pmcs_pkg::MD_WAKE;
			end
			pmcs_pkg::MD_WAKE: begin
				// No clocks until the selected source is ready again
				if (curReady && wantReady)
					mode_nxt = pmcs_pkg::MD_RUN;
			end
			default: mode_nxt = pmcs_pkg::MD_RUN;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Status follows the mode being entered, so Sleep clears it on that edge
	wire logic runOrIdle = ~sleepNxt & (mode_nxt != pmcs_pkg::MD_WAKE);
	// Handover end touches only status; select, idle and aux enable stay inputs
	wire logic stable    = ~busy;
	wire logic priActNxt = runOrIdle & stable & (curSrc == pmcs_pkg::SRC_PRI) & priReady;
	wire logic auxActNxt = runOrIdle & stable & (curSrc == pmcs_pkg::SRC_AUX);
	// Internal primary may show both primary and fast-stable set
	wire logic rcDrives  = (curSrc == pmcs_pkg::SRC_INT) |
		((curSrc == pmcs_pkg::SRC_PRI) & primaryIsInternal);
	wire logic fastNxt   = runOrIdle & stable & rcDrives & rcSync_r;
	wire logic cpuNxt    = devTick & (mode_nxt == pmcs_pkg::MD_RUN);
	wire logic perNxt    = devTick & runOrIdle;

	// Timer and mode registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_r     <= pmcs_pkg::MD_RUN;
			warmCnt_r  <= '0;
			warmDone_r <= 1'b1;
			priEn_r    <= 1'b1;
		end else begin
			mode_r     <= mode_nxt;
			warmCnt_r  <= warmCnt_nxt;
			warmDone_r <= warmDone_nxt;
			priEn_r    <= priEnNxt;
		end
	end

	// Output registers; sleep clears every tick and status bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cpuTick          <= 1'b0;
			periphTick       <= 1'b0;
			primaryOscEn     <= 1'b1;
			primaryClkActive <= pmcs_pkg::RST_PRI_ACTIVE;
			fastRcStable     <= 1'b0;
			auxOscActive     <= 1'b0;
			powerMode        <= 2'h0;
			switchBusy       <= 1'b0;
		end else begin
			cpuTick          <= cpuNxt;
			periphTick       <= perNxt;
			primaryOscEn     <= priEnNxt;
			primaryClkActive <= priActNxt;
			fastRcStable     <= fastNxt;
			auxOscActive     <= auxActNxt;
			powerMode        <= mode_nxt;
			switchBusy       <= busy;
		end
	end

endmodule

// file: rtl/pmcs_pkg.sv
package pmcs_pkg;

	// Clock source identifiers, also the index into the tick vector
	localparam logic [1:0] SRC_PRI = 2'h0;
	localparam logic [1:0] SRC_AUX = 2'h1;
	localparam logic [1:0] SRC_INT = 2'h2;
	localparam int         NUM_SRC = 3;

	// Select field encodings; bit 1 set means internal block
	localparam logic [1:0] SEL_PRI = 2'h0;
	localparam logic [1:0] SEL_AUX = 2'h1;
	localparam int         SEL_INT_BIT = 1;

	// Field positions of the status bits in their registers
	localparam int PRI_ACTIVE_BIT = 3;
	localparam int FAST_RC_BIT    = 2;
	localparam int AUX_ACTIVE_BIT = 6;

	// Handover length in source cycles: old, then new
	localparam int TRANS_OLD_CYC = 2;
	localparam int TRANS_NEW_CYC = 3;

	// Crystal start-up timer length in oscillator cycles
	localparam int WARMUP_CYCLES = 1024;

	// Power managed mode of the controller
	typedef enum logic [1:0] {
		MD_RUN,
		MD_IDLE,
		MD_SLEEP,
		MD_WAKE
	} pmcs_mode_t;

	// Handover sequencer state
	typedef enum logic [1:0] {
		MX_RUN,
		MX_OLD,
		MX_NEW
	} pmcs_mux_t;

	// Values after reset
	localparam logic       RST_PRI_ACTIVE = 1'b1;
	localparam logic [1:0] RST_SRC        = SRC_PRI;

endpackage

// file: rtl/pmcs_clk_mux.sv
// Glitch-free handover between oscillator tick streams
module pmcs_clk_mux #(
	parameter int OLD_CYC = pmcs_pkg::TRANS_OLD_CYC,
	parameter int NEW_CYC = pmcs_pkg::TRANS_NEW_CYC
) (
	input  wire logic        clk,       // System clock
	input  wire logic        sys_rst,   // Synchronous reset
	input  wire logic [1:0]  resetSrc,  // Source taken at reset
	input  wire logic [2:0]  srcTick,   // One pulse per source cycle
	input  wire logic        goReq,     // Start a handover
	input  wire logic [1:0]  goSrc,     // Source to hand over to
	input  wire logic        hold,      // Stop all device ticks
	output logic      [1:0]  curSrc,    // Source now clocking
	output logic             busy,      // Handover in progress
	output logic             devTick    // Gated device tick
);

	pmcs_pkg::pmcs_mux_t state_r, state_nxt;
	logic [1:0] curSrc_r, curSrc_nxt;
	logic [1:0] newSrc_r, newSrc_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic       devTick_r, devTick_nxt;

	wire logic oldTick = srcTick[curSrc_r];
	wire logic newTick = srcTick[newSrc_r];
	wire logic oldLast = (cnt_r == 3'(OLD_CYC - 1));
	wire logic newLast = (cnt_r == 3'(NEW_CYC - 1));

	assign curSrc  = curSrc_r;
	assign busy    = (state_r != pmcs_pkg::MX_RUN);
	assign devTick = devTick_r;

	////////////////////////////////////////////////////////////////////////
	// Sequencer: no tick passes while a handover runs, so no runt
	always_comb begin
		state_nxt   = state_r;
		curSrc_nxt  = curSrc_r;
		newSrc_nxt  = newSrc_r;
		cnt_nxt     = cnt_r;
		devTick_nxt = 1'b0;
		case (state_r)
			pmcs_pkg::MX_RUN: begin
				devTick_nxt = oldTick & ~hold;
				if (goReq) begin
					state_nxt  = pmcs_pkg::MX_OLD;
					newSrc_nxt = goSrc;
					cnt_nxt    = 3'h0;
				end
			end
			pmcs_pkg::MX_OLD: begin
				// Two old cycles let the old clock settle low
				if (oldTick) begin
					cnt_nxt = cnt_r + 3'h1;
					if (oldLast) begin
						state_nxt = pmcs_pkg::MX_NEW;
						cnt_nxt   = 3'h0;
					end
				end
			end
			pmcs_pkg::MX_NEW: begin
				// A silent new source stalls here, withholding clocks
				if (newTick) begin
					cnt_nxt = cnt_r + 3'h1;
					if (newLast) begin
						state_nxt  = pmcs_pkg::MX_RUN;
						curSrc_nxt = newSrc_r;
						cnt_nxt    = 3'h0;
					end
				end
			end
			default: state_nxt = pmcs_pkg::MX_RUN;
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r   <= pmcs_pkg::MX_RUN;
			curSrc_r  <= resetSrc;
			newSrc_r  <= resetSrc;
			cnt_r     <= 3'h0;
			devTick_r <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			curSrc_r  <= curSrc_nxt;
			newSrc_r  <= newSrc_nxt;
			cnt_r     <= cnt_nxt;
			devTick_r <= devTick_nxt;
		end
	end

endmodule

// file: tb/pmcs_switcher_assertions.sv
module pmcs_switcher_assertions #(
	parameter int WARM_CNT = 8
) (
	input wire logic       clk,               // System clock
	input wire logic       sys_rst,           // Synchronous reset
	input wire logic [1:0] clkSourceSelect,   // Source select
	input wire logic       idleOnHalt,        // Idle bit
	input wire logic       auxOscEnable,      // Aux enable
	input wire logic       haltExec,          // Halt pulse
	input wire logic       wakeEvent,         // Wake pulse
	input wire logic       primaryIsInternal, // Config
	input wire logic       twoSpeedStartup,   // Config
	input wire logic       cpuTick,           // CPU tick
	input wire logic       periphTick,        // Peripheral tick
	input wire logic       primaryOscEn,      // Primary enable
	input wire logic       primaryClkActive,  // Status
	input wire logic       fastRcStable,      // Status
	input wire logic       auxOscActive,      // Status
	input wire logic [1:0] powerMode,         // Mode code
	input wire logic       switchBusy         // Handover busy
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] M_RUN = 2'h0;
	localparam logic [1:0] M_IDLE = 2'h1;
	localparam logic [1:0] M_SLP = 2'h2;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////
	// Mode entry and exit
	property p_halt_sleep;
		haltExec && !idleOnHalt && powerMode == M_RUN |=> powerMode == M_SLP;
	endproperty
	a_halt_sleep: assert property (p_halt_sleep) else $error("halt did not sleep");
	property p_halt_idle;
		haltExec && idleOnHalt && powerMode == M_RUN && (clkSourceSelect != 2'h1 || auxOscEnable)
			|=> powerMode == M_IDLE;
	endproperty
	a_halt_idle: assert property (p_halt_idle) else $error("halt did not idle");
	property p_wake_idle;
		wakeEvent && powerMode == M_IDLE |=> powerMode == M_RUN;
	endproperty
	a_wake_idle: assert property (p_wake_idle) else $error("idle wake missed");
	// Reset value checked without the reset disable
	property p_reset;
		disable iff (1'b0) $fell(sys_rst) && !twoSpeedStartup |-> primaryClkActive && powerMode == M_RUN;
	endproperty
	a_reset: assert property (p_reset) else $error("bad state after reset");

	////////////////////////////////////////////////////////////////
	// Clock gating; three cycles let the tick pipeline drain
	property p_sleep_dark;
		powerMode == M_SLP |-> !primaryClkActive && !fastRcStable && !auxOscActive && !primaryOscEn;
	endproperty
	a_sleep_dark: assert property (p_sleep_dark) else $error("sleep status set");
	property p_sleep_tick;
		(powerMode == M_SLP) [*3] |-> !cpuTick && !periphTick;
	endproperty
	a_sleep_tick: assert property (p_sleep_tick) else $error("tick in sleep");
	property p_idle_cpu;
		(powerMode == M_IDLE) [*3] |-> !cpuTick;
	endproperty
	a_idle_cpu: assert property (p_idle_cpu) else $error("cpu tick in idle");
	property p_busy_dark;
		switchBusy [*3] |-> !cpuTick;
	endproperty
	a_busy_dark: assert property (p_busy_dark) else $error("tick in handover");

	////////////////////////////////////////////////////////////////
	// Status bits
	property p_onehot;
		!primaryIsInternal |-> $onehot0({primaryClkActive, fastRcStable, auxOscActive});
	endproperty
	a_onehot: assert property (p_onehot) else $error("status not onehot");
	property p_aux_en;
		$rose(auxOscActive) |-> auxOscEnable;
	endproperty
	a_aux_en: assert property (p_aux_en) else $error("aux run without enable");

	c_sleep: cover property (powerMode == M_SLP);
	c_idle: cover property (powerMode == M_IDLE);
	c_aux: cover property ($rose(auxOscActive));
	c_busy: cover property ($fell(switchBusy));
endmodule

// file: tb/pmcs_osc_model.sv
module pmcs_osc_model (
	input  wire logic primaryOscEn,   // Primary enable
	input  wire logic auxOscEnable,   // Aux enable
	input  wire logic auxSilent,      // Aux enabled, not started
	output logic      priOscPin,      // Primary output
	output logic      auxOscPin,      // Aux output
	output logic      intOscPin,      // Internal output
	output logic      fastRcReadyPin  // Fast internal stable
);
	timeunit 1ns;
	timeprecision 1ps;
	// Periods are whole multiples of the 5 ns system clock, edges fall on its falling edges
	initial begin
		priOscPin = 1'b0;
		auxOscPin = 1'b0;
		intOscPin = 1'b0;
		fastRcReadyPin = 1'b0;
	end
	// A stopped crystal rests low, so no stray edges
	always #20 priOscPin = primaryOscEn ? ~priOscPin : 1'b0;
	always #35 auxOscPin = (auxOscEnable && !auxSilent) ? ~auxOscPin : 1'b0;
	always #15 intOscPin = ~intOscPin;
	initial #100 fastRcReadyPin = 1'b1;
endmodule

// file: tb/tb_top.sv
`define CHECK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, a); end end
`define WAITC(c) for (k = 0; k < 3000 && !(c); k++) step(1);
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WARM = 8;
	logic       clk, sys_rst, idleOnHalt, auxOscEnable, haltExec, wakeEvent, priInt, auxSilent, twoSpd;
	logic       cpuTick, periphTick, primaryOscEn, primaryClkActive, fastRcStable, auxOscActive, switchBusy;
	logic       priOscPin, auxOscPin, intOscPin, fastRcReadyPin;
	logic [1:0] clkSourceSelect, powerMode;
	int         bad_count, cmp_count, cyc, k, cpuCnt, perCnt;

	pmcs_switcher #(.WARM_CNT(WARM)) dut (.clk(clk), .sys_rst(sys_rst), .clkSourceSelect(clkSourceSelect),
		.idleOnHalt(idleOnHalt), .auxOscEnable(auxOscEnable), .haltExec(haltExec), .wakeEvent(wakeEvent),
		.primaryIsInternal(priInt), .twoSpeedStartup(twoSpd), .priOscPin(priOscPin), .auxOscPin(auxOscPin),
		.intOscPin(intOscPin), .fastRcReadyPin(fastRcReadyPin), .cpuTick(cpuTick), .periphTick(periphTick),
		.primaryOscEn(primaryOscEn), .primaryClkActive(primaryClkActive), .fastRcStable(fastRcStable),
		.auxOscActive(auxOscActive), .powerMode(powerMode), .switchBusy(switchBusy));
	pmcs_osc_model osc (.primaryOscEn(primaryOscEn), .auxOscEnable(auxOscEnable), .auxSilent(auxSilent),
		.priOscPin(priOscPin), .auxOscPin(auxOscPin), .intOscPin(intOscPin), .fastRcReadyPin(fastRcReadyPin));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Tick counting and hang guard
	always @(posedge clk) begin
		cyc++;
		if (cpuTick === 1'b1) cpuCnt++;
		if (periphTick === 1'b1) perCnt++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////
	// Inputs change 1 ns after the edge
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task pulse(input logic isHalt);
		if (isHalt) haltExec = 1'b1;
		else wakeEvent = 1'b1;
		step(1);
		// Lower only what was raised, so a following pulse never rewrites it
		if (isHalt) haltExec = 1'b0;
		else wakeEvent = 1'b0;
	endtask
	task ticks(input int n);
		cpuCnt = 0;
		perCnt = 0;
		step(n);
	endtask
	task doReset(input logic pInt);
		sys_rst = 1'b1;
		priInt = pInt;
		step(4);
		sys_rst = 1'b0;
		step(1);
	endtask
	task swap(input logic [1:0] sel);
		clkSourceSelect = sel;
		`WAITC(switchBusy === 1'b1)
		`WAITC(switchBusy === 1'b0)
	endtask
	task stop_test;
		$display("Checks %0d, errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		{clkSourceSelect, idleOnHalt, auxOscEnable, haltExec, wakeEvent, auxSilent, twoSpd} = '0;
		{bad_count, cmp_count, cyc, cpuCnt, perCnt} = '0;
		doReset(1'b0);
		`CHECK("priActive", 3'b101, {primaryClkActive, auxOscActive, powerMode == 2'h0})
		ticks(200);
		`CHECK("cpuRun", 1'b1, cpuCnt > 15)
		`CHECK("perRun", cpuCnt, perCnt)
		// Idle first, then sleep after the idle bit changes
		idleOnHalt = 1'b1;
		pulse(1'b1);
		`CHECK("idle", 2'h1, powerMode)
		ticks(200);
		`CHECK("idleTicks", 2'b01, {cpuCnt > 0, perCnt > 15})
		`CHECK("priIdle", 1'b1, primaryClkActive)
		pulse(1'b0);
		idleOnHalt = 1'b0;
		`CHECK("woke", 2'h0, powerMode)
		pulse(1'b1);
		`CHECK("sleep", 2'h2, powerMode)
		`CHECK("slpStat", 4'h0, {primaryClkActive, fastRcStable, auxOscActive, primaryOscEn})
		ticks(100);
		`CHECK("slpTicks", 0, cpuCnt + perCnt)
		pulse(1'b0);
		`CHECK("wakeWait", 3'h7, {powerMode, primaryOscEn})
		`WAITC(powerMode === 2'h0)
		`CHECK("warmWait", 1'b1, k >= (WARM - 1) * 8)
		`CHECK("priBack", 1'b1, primaryClkActive)
		// Aux refused while disabled, then withheld while silent
		clkSourceSelect = 2'h1;
		step(200);
		`CHECK("auxOff", 2'b10, {primaryClkActive, auxOscActive})
		auxSilent = 1'b1;
		auxOscEnable = 1'b1;
		step(10);
		ticks(200);
		`CHECK("withheld", 0, cpuCnt)
		auxSilent = 1'b0;
		`WAITC(auxOscActive === 1'b1)
		`CHECK("auxRun", 3'b010, {primaryClkActive, auxOscActive, primaryOscEn})
		// Back to primary waits for its start-up count
		clkSourceSelect = 2'h0;
		`WAITC(primaryClkActive === 1'b1)
		`CHECK("holdAux", 1'b1, k >= (WARM - 1) * 8)
		`CHECK("auxClr", 1'b0, auxOscActive)
		swap(2'h3);
		`CHECK("xferLen", 1'b1, k >= 20 && k <= 45)
		step(2);
		`CHECK("intRun", 3'b010, {primaryClkActive, fastRcStable, primaryOscEn})
		// Internal block as primary source
		clkSourceSelect = 2'h0;
		doReset(1'b1);
		step(20);
		`CHECK("bothSet", 2'b11, {primaryClkActive, fastRcStable})
		swap(2'h2);
		step(2);
		`CHECK("priClr", 2'b01, {primaryClkActive, fastRcStable})
		// Two-speed start: internal source first, then handover to primary
		clkSourceSelect = 2'h0;
		twoSpd = 1'b1;
		doReset(1'b0);
		`CHECK("twoSpdInt", 1'b0, primaryClkActive)
		`WAITC(primaryClkActive === 1'b1)
		`CHECK("twoSpdPri", 2'b10, {primaryClkActive, fastRcStable})
		stop_test();
	end
endmodule

bind pmcs_switcher pmcs_switcher_assertions #(.WARM_CNT(WARM_CNT)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.clkSourceSelect(clkSourceSelect), .idleOnHalt(idleOnHalt), .auxOscEnable(auxOscEnable),
	.haltExec(haltExec), .wakeEvent(wakeEvent), .primaryIsInternal(primaryIsInternal),
	.twoSpeedStartup(twoSpeedStartup), .cpuTick(cpuTick), .periphTick(periphTick),
	.primaryOscEn(primaryOscEn), .primaryClkActive(primaryClkActive), .fastRcStable(fastRcStable),
	.auxOscActive(auxOscActive), .powerMode(powerMode), .switchBusy(switchBusy));
